// [common/long_timer_regs.svh]
// Constants of the event-linked long interval timer
`ifndef LONG_TIMER_REGS_SVH
`define LONG_TIMER_REGS_SVH

// ************************************************************
// Timing
// ************************************************************
`define SUB_CLK_HZ     32768
`define SUB_TICKS_SEC  15'h7fff
`define SUB_TICK_W     15
`define CNT_W          16
`define CNT_RELOAD     16'h0005
`define CNT_ZERO       16'h0000
`define CNT_ONE        16'h0001
`define SUB_TICK_ZERO  15'h0000
`define SUB_TICK_ONE   15'h0001

`endif

// [common/long_timer_pkg.sv]
// Types shared by the long interval timer files
package long_timer_pkg;
  // Host control bits
  typedef struct packed {
    logic count_start_bit;    // Run the down-counter
    logic event_src_sel;      // 1: linked event is count source
    logic link_enable;        // Route clock event to channel 0
    logic clock_enable;       // Run the seconds clock block
    logic clock_wait_request; // Freeze seconds counter for access
  } ctrl_s;

  // Device status
  typedef struct packed {
    logic underflow_flag;     // Sticky underflow
    logic clock_wait_status;  // Seconds counter frozen
  } stat_s;

  // Seconds clock states, Gray along the usual path
  typedef enum logic [1:0] {
    CLK_IDLE = 2'b00,
    CLK_RUN  = 2'b01,
    CLK_WAIT = 2'b11
  } clk_state_e;
endpackage

// [hdl/seconds_clock.sv]
// Seconds clock block driven by the subsystem clock enable
`include "long_timer_regs.svh"
module seconds_clock (
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  input  wire logic                   ce,
  input  wire logic                   sub_tick,
  input  wire logic                   run,
  input  wire logic                   wait_req,
  output logic                        sec_event,
  output logic                        wait_status
);
  import long_timer_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  clk_state_e             state_q;   // Run / wait
  clk_state_e             state_d;
  logic [`SUB_TICK_W-1:0] div_q;     // Subsystem tick divider
  logic [`SUB_TICK_W-1:0] div_d;
  logic                   wrap;      // Second boundary
  logic                   counting;  // Divider advances this cycle

  // A wait request freezes the divider at once, so no second can
  // complete on the same edge that the wait status goes high
  assign counting = run && (state_q == CLK_RUN) && !wait_req &&
                    sub_tick;
  assign wrap = counting && (div_q == `SUB_TICKS_SEC);
  // Divider runs only on subsystem ticks so the main clock rate
  // never changes the second length
  assign div_d = !run ? `SUB_TICK_ZERO :
                 !counting ? div_q :
                 wrap ? `SUB_TICK_ZERO : div_q + `SUB_TICK_ONE;

  // Next state of the wait handshake
  always_comb begin
    case (state_q)
      CLK_IDLE: state_d = run ? CLK_RUN : CLK_IDLE;
      CLK_RUN:  state_d = !run ? CLK_IDLE :
                          wait_req ? CLK_WAIT : CLK_RUN;
      CLK_WAIT: state_d = !run ? CLK_IDLE :
                          wait_req ? CLK_WAIT : CLK_RUN;
      default:  state_d = CLK_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= CLK_IDLE;
      div_q       <= `SUB_TICK_ZERO;
      sec_event   <= 1'b0;
      wait_status <= 1'b0;
    end else if (ce) begin
      state_q     <= state_d;
      div_q       <= div_d;
      // Pulse in the cycle after the divider wraps
      sec_event   <= wrap;
      wait_status <= (state_d == CLK_WAIT);
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_sec_wrap;
    @(posedge clock) disable iff (!arst_n)
      ce && wrap |=> sec_event;
  endproperty
  a_sec_wrap: assert property (p_sec_wrap)
    else $error("second event missing after divider wrap");

  property p_no_event_in_wait;
    @(posedge clock) disable iff (!arst_n)
      wait_status |-> !sec_event;
  endproperty
  a_no_event_in_wait: assert property (p_no_event_in_wait)
    else $error("second event while seconds counter frozen");

  property p_wait_release;
    @(posedge clock) disable iff (!arst_n)
      ce && wait_status && !wait_req && run |=> !wait_status;
  endproperty
  a_wait_release: assert property (p_wait_release)
    else $error("wait status not cleared after release");
endmodule

// [hdl/long_interval_timer.sv]
// Event-linked long interval timer top
`include "long_timer_regs.svh"
module long_interval_timer (
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  input  wire logic                   ce,
  input  wire logic                   subsystem_clock,
  input  long_timer_pkg::ctrl_s       ctrl,
  input  wire logic                   underflow_clear,
  input  wire logic                   pin_init_low,
  input  wire logic                   pin_toggle,
  input  wire logic                   core_stopped,
  output long_timer_pkg::stat_s       stat,
  output logic                        clock_fixed_cycle_irq,
  output logic                        underflow_irq,
  output logic                        wake_up,
  output logic [`CNT_W-1:0]           count_value,
  output logic                        toggle_output_pin
);
  import long_timer_pkg::*;

  // ************************************************************
  // Seconds clock
  // ************************************************************
  logic sec_event;    // One-cycle pulse per second
  logic wait_status;  // Seconds counter frozen

  seconds_clock u_clk (
    .clock       (clock),
    .arst_n      (arst_n),
    .ce          (ce),
    .sub_tick    (subsystem_clock),
    .run         (ctrl.clock_enable),
    .wait_req    (ctrl.clock_wait_request),
    .sec_event   (sec_event),
    .wait_status (wait_status)
  );

  // ************************************************************
  // Event link and down-counter channel 0
  // ************************************************************
  // Core halt is deliberately not an input of this logic, so
  // the chain keeps counting while the core is stopped
  logic linked_event;  // Event arriving at the count source
  logic count_step;    // Counter decrements this cycle
  logic underflow;     // Counter steps from one and reloads
  logic [`CNT_W-1:0] cnt_q;
  logic [`CNT_W-1:0] cnt_d;
  logic flag_q;
  logic flag_d;

  assign linked_event = ctrl.link_enable && sec_event;
  assign count_step   = ctrl.count_start_bit &&
                        ctrl.event_src_sel && linked_event;
  // With reload 5 the counter visits 5..1, so the underflow from
  // one lands on the fifth event after the first reload
  assign underflow    = count_step && (cnt_q == `CNT_ONE);
  assign cnt_d = !ctrl.count_start_bit ? `CNT_RELOAD :
                 !count_step ? cnt_q :
                 underflow ? `CNT_RELOAD : cnt_q - `CNT_ONE;
  // Set wins over a clear in the same cycle
  assign flag_d = underflow | (flag_q & ~underflow_clear);

  // Counter, flag and interrupt registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q                 <= `CNT_RELOAD;
      flag_q                <= 1'b0;
      clock_fixed_cycle_irq <= 1'b0;
      underflow_irq         <= 1'b0;
      wake_up               <= 1'b0;
      count_value           <= `CNT_RELOAD;
      stat                  <= '0;
    end else if (ce) begin
      cnt_q                 <= cnt_d;
      flag_q                <= flag_d;
      clock_fixed_cycle_irq <= sec_event;
      underflow_irq         <= underflow;
      wake_up               <= underflow && core_stopped;
      count_value           <= cnt_d;
      stat.underflow_flag   <= flag_d;
      stat.clock_wait_status <= wait_status;
    end
  end

  // ************************************************************
  // Output pin driven by software
  // ************************************************************
  // Pin written only by host strobes; init has priority
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      toggle_output_pin <= 1'b0;
    end else if (ce) begin
      if (pin_init_low) begin
        toggle_output_pin <= 1'b0;
      end else if (pin_toggle) begin
        toggle_output_pin <= ~toggle_output_pin;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_event_link;
    @(posedge clock) disable iff (!arst_n)
      ce && sec_event && ctrl.link_enable && ctrl.count_start_bit &&
      ctrl.event_src_sel && cnt_q > `CNT_ONE
      |=> count_value == $past(cnt_q) - `CNT_ONE;
  endproperty
  a_event_link: assert property (p_event_link)
    else $error("linked event did not decrement counter");

  property p_decrement_only_on_event;
    @(posedge clock) disable iff (!arst_n)
      ce && !count_step && ctrl.count_start_bit |=> cnt_q == $past(cnt_q);
  endproperty
  a_decrement_only_on_event: assert property (p_decrement_only_on_event)
    else $error("counter moved without a linked event");

  property p_underflow_reload;
    @(posedge clock) disable iff (!arst_n)
      ce && underflow |=> underflow_irq && cnt_q == `CNT_RELOAD;
  endproperty
  a_underflow_reload: assert property (p_underflow_reload)
    else $error("underflow did not raise irq and reload 5");

  property p_flag_set_wins;
    @(posedge clock) disable iff (!arst_n)
      ce && underflow && underflow_clear |=> stat.underflow_flag;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins)
    else $error("underflow flag lost to simultaneous clear");

  property p_flag_clear;
    @(posedge clock) disable iff (!arst_n)
      ce && underflow_clear && !underflow |=> !stat.underflow_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("underflow flag not cleared by host");

  property p_wake;
    @(posedge clock) disable iff (!arst_n)
      ce && underflow && core_stopped |=> wake_up;
  endproperty
  a_wake: assert property (p_wake)
    else $error("underflow did not wake a stopped core");

  property p_pin_init;
    @(posedge clock) disable iff (!arst_n)
      ce && pin_init_low |=> !toggle_output_pin;
  endproperty
  a_pin_init: assert property (p_pin_init)
    else $error("pin not driven low by init");

  property p_pin_toggle;
    @(posedge clock) disable iff (!arst_n)
      ce && pin_toggle && !pin_init_low
      |=> toggle_output_pin != $past(toggle_output_pin);
  endproperty
  a_pin_toggle: assert property (p_pin_toggle)
    else $error("pin did not invert on toggle");
endmodule

// [testbench/core_model.sv]
// Processor core model serving the underflow wake-up
module core_model #(
  parameter int RESP_DLY = 2  // Wake-up latency, cycles
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic wake_up,
  output logic      pin_toggle,
  output logic      underflow_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_q;  // Cycles left before service
  // ************************************************
  // Wake-up service, slow on purpose like real code
  // ************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wait_q          <= 8'h00;
      pin_toggle      <= 1'b0;
      underflow_clear <= 1'b0;
    end else begin
      pin_toggle      <= (wait_q == 8'h01);
      underflow_clear <= (wait_q == 8'h01);
      if (wake_up) begin
        wait_q <= 8'(RESP_DLY);
      end else if (wait_q != 8'h00) begin
        wait_q <= wait_q - 8'h01;
      end
    end
  end
endmodule

// [testbench/long_interval_timer_tb.sv]
// Testbench of the long interval timer
`include "long_timer_regs.svh"
module long_interval_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import long_timer_pkg::*;
  logic clock, arst_n, ce, subsystem_clock, pin_init_low, core_stopped;
  logic pin_toggle, underflow_clear, fc_irq, uf_irq, wake_up, pin;
  ctrl_s ctrl;               // Host control bits
  stat_s stat;               // Device status
  logic [15:0] count_value;  // Counter value
  int num_errors, tests_run;
  long_interval_timer long_interval_timer_inst (
    .clock(clock), .arst_n(arst_n), .ce(ce),
    .subsystem_clock(subsystem_clock), .ctrl(ctrl),
    .underflow_clear(underflow_clear), .pin_init_low(pin_init_low),
    .pin_toggle(pin_toggle), .core_stopped(core_stopped),
    .stat(stat), .clock_fixed_cycle_irq(fc_irq),
    .underflow_irq(uf_irq), .wake_up(wake_up),
    .count_value(count_value), .toggle_output_pin(pin));
  core_model core_model_inst (
    .clock(clock), .arst_n(arst_n), .wake_up(wake_up),
    .pin_toggle(pin_toggle), .underflow_clear(underflow_clear));
  // ************************************************
  // Clock and helpers
  // ************************************************
  always #5 clock = ~clock;
  // Advance n edges, then sample once settled
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ************************************************
  // Scenarios
  // ************************************************
  // Frozen seconds counter must report wait and drop no event
  task automatic t_wait;
    ctrl.clock_enable <= 1'b1;
    ctrl.clock_wait_request <= 1'b1;
    tick(3);
    chk(16'(stat.clock_wait_status), 16'h0001);
    tick(50);
    chk(16'(fc_irq), 16'h0000);
    ctrl.clock_wait_request <= 1'b0;
    tick(3);
    chk(16'(stat.clock_wait_status), 16'h0000);
    ctrl.clock_enable <= 1'b0;
    tick(1);
  endtask
  // Five linked seconds, then underflow wakes the stopped core
  task automatic t_run;
    int n;
    ctrl <= 5'b11110;
    core_stopped <= 1'b1;
    tick(1);
    for (int s = 1; s <= 5; s++) begin
      n = 0;
      do begin
        tick(1);
        n++;
      end while (fc_irq !== 1'b1 && n < 40000);
      if (n >= 40000) begin
        num_errors++;
        finish_test();
      end
      if (s > 1) chk(16'(n), 16'h8000);
      chk(count_value, s == 5 ? `CNT_RELOAD : 16'(5 - s));
      chk(16'(uf_irq), 16'(s == 5));
      chk(16'(wake_up), 16'(s == 5));
      chk(16'(stat.underflow_flag), 16'(s == 5));
    end
    tick(10);
    chk(16'(pin), 16'h0001);
    chk(16'(stat.underflow_flag), 16'h0000);
  endtask
  // Pin forced low and counter stopped back at reload
  task automatic t_stop;
    pin_init_low <= 1'b1;
    ctrl.count_start_bit <= 1'b0;
    tick(1);
    pin_init_low <= 1'b0;
    tick(2);
    chk(16'(pin), 16'h0000);
    chk(count_value, `CNT_RELOAD);
  endtask
  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    subsystem_clock = 1'b1;
    ctrl = '0;
    pin_init_low = 1'b0;
    core_stopped = 1'b0;
    num_errors = 0;
    tests_run = 0;
    tick(8);
    chk(count_value, `CNT_RELOAD);
    chk({14'h0, stat}, 16'h0000);
    arst_n <= 1'b1;
    tick(1);
    t_wait();
    t_run();
    t_stop();
    finish_test();
  end
endmodule
